// >>> include/adc_port_pkg.sv
// Constants and types for the parallel readout port of the SAR converter
// Summary of operation
// - Conversion-done flag falls when result is ready
// - Data bus released during acquisition and conversion
// - Third chip-select fall, read high, drives result
// - Chip select rising in read releases bus
// - After read, idle until next chip-select fall
// - Wide bus parallel result, narrow bus bytewise
// - High-byte select low gives low byte
// - Reset pin with chip select high restarts
// - Result coded in straight binary
// - First fall with read low starts acquisition
// - Second fall ends acquisition, starts conversion
// - Second fall samples standby versus shutdown
// - Conversion finishes within 4.7 microseconds
`default_nettype none
package adc_port_pkg;
  localparam int unsigned RESULT_W = 14;
  localparam int unsigned BYTE_W = 8;
  localparam real CLK_PERIOD_NS = 5.0;
  localparam real CONV_TIME_MAX_US = 4.7;
  localparam int unsigned CONV_CYCLES = int'($floor(CONV_TIME_MAX_US * 1000.0 / CLK_PERIOD_NS));
  localparam int unsigned STEP_CYCLES = (CONV_CYCLES - 1) / RESULT_W;
  localparam int unsigned AGE_W = 10;
  localparam logic [RESULT_W-1:0] BUS_IDLE = 14'h0000;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_ACQ = 3'b001,
    ST_CONV = 3'b010,
    ST_DONE = 3'b011,
    ST_READ = 3'b100
  } phase_e;

  // Bus word for the result: whole word, or one zero-extended byte
  function automatic logic [RESULT_W-1:0] bus_word(input logic [RESULT_W-1:0] res,
                                                   input logic wide, input logic hi);
    logic [RESULT_W-1:0] w;
    w = res;
    if (!wide)
    begin
      if (hi)
        w = {{(RESULT_W - BYTE_W){1'b0}}, {(2 * BYTE_W - RESULT_W){1'b0}},
             res[RESULT_W-1:BYTE_W]};
      else
        w = {{(RESULT_W - BYTE_W){1'b0}}, res[BYTE_W-1:0]};
    end
    return w;
  endfunction
endpackage
`default_nettype wire

// >>> logic/sar_engine.sv
// Successive approximation engine with a fixed conversion length
`timescale 1ns/1ps
`default_nettype none
module sar_engine
#(
  parameter int unsigned W = 14,
  parameter int unsigned CYCLES = 940,
  parameter int unsigned STEP = 67
)
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Control
  input wire logic i_start,
  input wire logic i_abort,
  input wire logic [W-1:0] i_sample,
  // Result
  output logic o_done,
  output logic [W-1:0] o_result
);
  localparam int unsigned TOT_W = $clog2(CYCLES);
  localparam int unsigned STEP_W = $clog2(STEP + 1);

  // Last trial bit must settle one cycle before the result is latched
  if (STEP < 1 || CYCLES < 3 || STEP * W + 2 > CYCLES)
  begin : g_bad_counts
    $error("sar_engine: step and cycle counts cannot fit");
  end

  logic busy_r, busy_nxt;
  logic [TOT_W-1:0] tot_r, tot_nxt;
  logic [STEP_W-1:0] step_r, step_nxt;
  logic [W-1:0] mask_r, mask_nxt;
  logic [W-1:0] held_r, held_nxt;
  logic [W-1:0] trial_r, trial_nxt;
  logic [W-1:0] result_r, result_nxt;
  logic done;

  assign done = busy_r && (tot_r == TOT_W'(CYCLES - 2));
  assign o_done = done;
  assign o_result = result_r;

  always_comb
  begin
    busy_nxt = busy_r;
    tot_nxt = tot_r;
    step_nxt = step_r;
    mask_nxt = mask_r;
    held_nxt = held_r;
    trial_nxt = trial_r;
    result_nxt = result_r;
    if (i_abort)
    begin
      busy_nxt = 1'b0;
    end
    else if (i_start)
    begin
      busy_nxt = 1'b1;
      tot_nxt = '0;
      step_nxt = '0;
      mask_nxt = {1'b1, {(W - 1){1'b0}}};
      held_nxt = i_sample;
      trial_nxt = '0;
    end
    else if (busy_r)
    begin
      tot_nxt = tot_r + 1'b1;
      if (step_r == STEP_W'(STEP - 1))
      begin
        step_nxt = '0;
        // Keep a trial bit when it does not overshoot the held sample
        if (mask_r != '0 && (trial_r | mask_r) <= held_r)
          trial_nxt = trial_r | mask_r;
        mask_nxt = mask_r >> 1;
      end
      else
      begin
        step_nxt = step_r + 1'b1;
      end
      if (done)
      begin
        busy_nxt = 1'b0;
        result_nxt = trial_r;
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      busy_r <= 1'b0;
      tot_r <= '0;
      step_r <= '0;
      mask_r <= '0;
      held_r <= '0;
      trial_r <= '0;
      result_r <= '0;
    end
    else
    begin
      busy_r <= busy_nxt;
      tot_r <= tot_nxt;
      step_r <= step_nxt;
      mask_r <= mask_nxt;
      held_r <= held_nxt;
      trial_r <= trial_nxt;
      result_r <= result_nxt;
    end
  end
endmodule
`default_nettype wire

// >>> logic/adc_parallel_readout_port.sv
// Chip-select sequencer and three-state result bus of the converter
`timescale 1ns/1ps
`default_nettype none
module adc_parallel_readout_port
#(
  parameter bit WIDE_BUS = 1'b1
)
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Host control pins
  input wire logic i_cs_n,
  input wire logic i_read_conv,
  input wire logic i_high_byte_select,
  input wire logic i_reset_pin,
  // Sampled analog input as a code
  input wire logic [adc_port_pkg::RESULT_W-1:0] i_sample,
  // Conversion-done flag
  output logic o_conv_done_n,
  // Result bus
  output logic [adc_port_pkg::RESULT_W-1:0] o_result_bus,
  output logic o_result_bus_oe,
  // Power and phase status
  output logic o_ref_shutdown,
  output logic o_tracking,
  output logic o_holding
);
  import adc_port_pkg::*;

  phase_e state_r, state_nxt;
  logic cs_prev_r;
  logic mode_r, mode_nxt;
  logic low_power_r, low_power_nxt;
  logic eoc_n_r, eoc_n_nxt;
  logic [RESULT_W-1:0] bus_r, bus_nxt;
  logic oe_r, oe_nxt;
  logic [AGE_W-1:0] conv_age_r, conv_age_nxt;
  logic cs_fall, cs_rise, pin_reset, conv_start, conv_done;
  logic [RESULT_W-1:0] result;
  logic [RESULT_W-1:0] sel_word;

  assign cs_fall = cs_prev_r && !i_cs_n;
  assign cs_rise = !cs_prev_r && i_cs_n;
  assign pin_reset = i_reset_pin && i_cs_n;
  assign conv_start = (state_r == ST_ACQ) && cs_fall && !pin_reset;
  assign sel_word = bus_word(result, WIDE_BUS, i_high_byte_select);

  sar_engine
  #(
    .W(RESULT_W),
    .CYCLES(CONV_CYCLES),
    .STEP(STEP_CYCLES)
  )
  u_sar
  (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_start(conv_start),
    .i_abort(pin_reset),
    .i_sample(i_sample),
    .o_done(conv_done),
    .o_result(result)
  );

  always_comb
  begin
    state_nxt = state_r;
    mode_nxt = mode_r;
    low_power_nxt = low_power_r;
    eoc_n_nxt = eoc_n_r;
    bus_nxt = bus_r;
    oe_nxt = oe_r;
    conv_age_nxt = conv_age_r;
    if (pin_reset)
    begin
      // Known state; next fall with read/convert low starts acquisition
      state_nxt = ST_IDLE;
      mode_nxt = 1'b0;
      low_power_nxt = 1'b0;
      eoc_n_nxt = 1'b1;
      oe_nxt = 1'b0;
      bus_nxt = BUS_IDLE;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE:
        begin
          // Start only with read/convert low
          if (cs_fall && !i_read_conv)
          begin
            state_nxt = ST_ACQ;
            eoc_n_nxt = 1'b1;
            low_power_nxt = 1'b0;
          end
        end
        ST_ACQ:
        begin
          conv_age_nxt = '0;
          if (cs_fall)
          begin
            state_nxt = ST_CONV;
            mode_nxt = i_read_conv;
          end
        end
        ST_CONV:
        begin
          conv_age_nxt = conv_age_r + 1'b1;
          if (conv_done)
          begin
            state_nxt = ST_DONE;
            eoc_n_nxt = 1'b0;
            low_power_nxt = mode_r;
          end
        end
        ST_DONE:
        begin
          if (cs_fall && i_read_conv)
          begin
            state_nxt = ST_READ;
            oe_nxt = 1'b1;
            bus_nxt = sel_word;
          end
        end
        ST_READ:
        begin
          if (cs_rise)
          begin
            state_nxt = ST_IDLE;
            oe_nxt = 1'b0;
            bus_nxt = BUS_IDLE;
          end
          else
          begin
            bus_nxt = sel_word;
          end
        end
        default:
        begin
          state_nxt = ST_IDLE;
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_r <= ST_IDLE;
      cs_prev_r <= 1'b1;
      mode_r <= 1'b0;
      low_power_r <= 1'b0;
      eoc_n_r <= 1'b1;
      bus_r <= BUS_IDLE;
      oe_r <= 1'b0;
      conv_age_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      cs_prev_r <= i_cs_n;
      mode_r <= mode_nxt;
      low_power_r <= low_power_nxt;
      eoc_n_r <= eoc_n_nxt;
      bus_r <= bus_nxt;
      oe_r <= oe_nxt;
      conv_age_r <= conv_age_nxt;
    end
  end

  assign o_conv_done_n = eoc_n_r;
  assign o_result_bus = bus_r;
  assign o_result_bus_oe = oe_r;
  assign o_ref_shutdown = low_power_r;
  assign o_tracking = (state_r == ST_ACQ);
  assign o_holding = (state_r == ST_CONV);

  // Checks
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  logic [RESULT_W-1:0] held_sample_r;
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      held_sample_r <= '0;
    else if (conv_start)
      held_sample_r <= i_sample;
  end

  property p_done_flag;
    (state_r == ST_CONV) && conv_done && !pin_reset |=> !o_conv_done_n && state_r == ST_DONE;
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("done flag did not fall");

  property p_bus_released;
    (state_r == ST_ACQ || state_r == ST_CONV) |-> !o_result_bus_oe;
  endproperty
  a_bus_released: assert property (p_bus_released) else $error("bus driven early");

  property p_read_drive;
    (state_r == ST_DONE) && cs_fall && i_read_conv && !pin_reset
      |=> o_result_bus_oe && o_result_bus == $past(sel_word);
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("result not driven");

  property p_release_on_rise;
    (state_r == ST_READ) && cs_rise |=> !o_result_bus_oe ##1 !o_result_bus_oe;
  endproperty
  a_release_on_rise: assert property (p_release_on_rise) else $error("bus not released");

  property p_idle_wait;
    (state_r == ST_IDLE) && !cs_fall |=> state_r == ST_IDLE;
  endproperty
  a_idle_wait: assert property (p_idle_wait) else $error("left idle without edge");

  property p_byte_follow;
    (state_r == ST_READ) && !cs_rise && !pin_reset
      |=> o_result_bus_oe && o_result_bus == bus_word(result, WIDE_BUS, $past(i_high_byte_select));
  endproperty
  a_byte_follow: assert property (p_byte_follow) else $error("byte select ignored");

  property p_narrow_bus;
    o_result_bus_oe && !WIDE_BUS |-> o_result_bus[RESULT_W-1:BYTE_W] == '0;
  endproperty
  a_narrow_bus: assert property (p_narrow_bus) else $error("narrow bus too wide");

  property p_pin_reset;
    pin_reset |=> state_r == ST_IDLE && o_conv_done_n && !o_result_bus_oe;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("reset pin ignored");

  property p_binary;
    $fell(o_conv_done_n) |-> result == held_sample_r;
  endproperty
  a_binary: assert property (p_binary) else $error("result not straight binary");

  property p_start_ignored;
    (state_r == ST_IDLE) && cs_fall && i_read_conv && !pin_reset |=> state_r == ST_IDLE;
  endproperty
  a_start_ignored: assert property (p_start_ignored) else $error("start not ignored");

  property p_hold_mode;
    conv_start |=> o_holding && mode_r == $past(i_read_conv);
  endproperty
  a_hold_mode: assert property (p_hold_mode) else $error("hold or mode wrong");

  property p_conv_time;
    $fell(o_conv_done_n) |-> conv_age_r == AGE_W'(CONV_CYCLES - 1);
  endproperty
  a_conv_time: assert property (p_conv_time) else $error("conversion time wrong");

  property p_shutdown_entry;
    $fell(o_conv_done_n) |-> o_ref_shutdown == mode_r;
  endproperty
  a_shutdown_entry: assert property (p_shutdown_entry) else $error("power mode wrong");

  c_full_cycle: cover property ((state_r == ST_READ) && cs_rise);
  c_shutdown: cover property ($rose(o_ref_shutdown));
  c_both_bytes: cover property ((state_r == ST_READ) && $changed(i_high_byte_select));
  c_reset_pin: cover property (pin_reset && state_r == ST_CONV);
endmodule
`default_nettype wire

// >>> testbench/host_model.sv
// Host processor model driving the converter control pins
`timescale 1ns/1ps
`default_nettype none
module host_model
(
  // Requests from the test sequence
  input wire logic i_select,
  input wire logic i_read_req,
  input wire logic i_high_req,
  input wire logic i_reset_req,
  // Control pins toward the converter
  output logic o_cs_n,
  output logic o_read_conv,
  output logic o_high_byte_select,
  output logic o_reset_pin
);
  // Pins follow the requests; the reset pin is held back while selected
  always_comb
  begin
    o_cs_n = !i_select;
    o_read_conv = i_read_req;
    o_high_byte_select = i_high_req;
    o_reset_pin = i_reset_req && !i_select;
  end
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking bench for the readout port, narrow and wide variants
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import adc_port_pkg::*;
  logic i_clock;
  logic i_rst;
  logic [RESULT_W-1:0] sample;
  logic cs_n, rc, hb, rpin;
  logic sel_req, rd_req, hi_req, rst_req;
  logic [1:0] done_n, oe, shut, trk, hld;
  logic [RESULT_W-1:0] bus [2];
  logic [RESULT_W-1:0] exp_q [$];
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;

  host_model host (.i_select(sel_req), .i_read_req(rd_req), .i_high_req(hi_req),
    .i_reset_req(rst_req), .o_cs_n(cs_n), .o_read_conv(rc),
    .o_high_byte_select(hb), .o_reset_pin(rpin));

  adc_parallel_readout_port #(.WIDE_BUS(1'b0)) dut (.i_clock(i_clock), .i_rst(i_rst),
    .i_cs_n(cs_n), .i_read_conv(rc), .i_high_byte_select(hb), .i_reset_pin(rpin),
    .i_sample(sample), .o_conv_done_n(done_n[0]), .o_result_bus(bus[0]),
    .o_result_bus_oe(oe[0]), .o_ref_shutdown(shut[0]), .o_tracking(trk[0]),
    .o_holding(hld[0]));

  adc_parallel_readout_port #(.WIDE_BUS(1'b1)) dut_wide (.i_clock(i_clock), .i_rst(i_rst),
    .i_cs_n(cs_n), .i_read_conv(rc), .i_high_byte_select(hb), .i_reset_pin(rpin),
    .i_sample(sample), .o_conv_done_n(done_n[1]), .o_result_bus(bus[1]),
    .o_result_bus_oe(oe[1]), .o_ref_shutdown(shut[1]), .o_tracking(trk[1]),
    .o_holding(hld[1]));

  initial
  begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end

  task automatic final_report();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask

  // Chip select falls with the given read/convert level and stays low
  task automatic cs_low(input logic level);
    @(posedge i_clock);
    #1;
    rd_req = level;
    sel_req = 1'b1;
  endtask

  // Chip select rises; at least two high samples before the next fall
  task automatic cs_high();
    @(posedge i_clock);
    #1;
    sel_req = 1'b0;
    @(posedge i_clock);
    #1;
  endtask

  // Host picks which byte it reads
  task automatic byte_sel(input logic hi);
    @(posedge i_clock);
    #1;
    hi_req = hi;
  endtask

  // Reset pin pulse while chip select is high
  task automatic pulse_reset();
    @(posedge i_clock);
    #1;
    rst_req = 1'b1;
    @(posedge i_clock);
    #1;
    rst_req = 1'b0;
  endtask

  // One full cycle: start, hold, wait for done, then read or reset pin
  task automatic run_conversion(input int k);
    logic mode;
    logic [RESULT_W-1:0] s;
    int n;
    logic leak;
    mode = k[0];
    s = (k == 0) ? 14'h3fff : (k == 1) ? 14'h0000 : 14'($urandom);
    sample = s;
    cs_low(1'b0);
    settle(2);
    check({trk, done_n, oe}, 16'h003c);
    cs_high();
    cs_low(mode);
    exp_q.push_back(s);
    n = 0;
    leak = 1'b0;
    while (done_n[0] !== 1'b0 && n < 2000)
    begin
      settle(1);
      n++;
      leak |= (oe !== 2'h0);
      if (n == 2)
        check({hld, trk}, 16'h000c);
    end
    check(16'(n), 16'(CONV_CYCLES));
    check(leak, 1'b0);
    check({done_n, hld, shut}, {4'h0, mode, mode});
    cs_high();
    repeat ($urandom_range(0, 4)) @(posedge i_clock);
    s = exp_q.pop_front();
    if (k == 3)
    begin
      pulse_reset();
      settle(1);
      check({done_n, oe, shut}, 16'h0030);
      cs_low(1'b1);
      settle(2);
      check({oe, trk}, 16'h0000);
      cs_high();
      return;
    end
    cs_low(1'b0);
    settle(2);
    check({oe, done_n}, 16'h0000);
    cs_high();
    cs_low(1'b1);
    settle(2);
    check(bus[1], s);
    check({oe, bus[0]}, {2'h3, 6'h00, s[7:0]});
    byte_sel(1'b1);
    settle(2);
    check(bus[0], {8'h00, s[13:8]});
    check({oe, bus[1]}, {2'h3, s});
    byte_sel(1'b0);
    cs_high();
    settle(1);
    check({oe, trk, hld}, 16'h0000);
    check(bus[1], 16'h0000);
  endtask

  always @(posedge i_clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      final_report();
    end
  end

  initial
  begin
    i_rst = 1'b1;
    sample = 14'h0000;
    sel_req = 1'b0;
    rd_req = 1'b0;
    hi_req = 1'b0;
    rst_req = 1'b0;
    void'($urandom(99));
    repeat (8) @(posedge i_clock);
    #1;
    i_rst = 1'b0;
    check({done_n, oe, trk, hld}, 16'h00c0);
    cs_low(1'b1);
    settle(2);
    check({trk, oe}, 16'h0000);
    cs_high();
    for (int k = 0; k < 8; k++)
      run_conversion(k);
    final_report();
  end
endmodule
`default_nettype wire
